/* core/sts_seq.sv */
// Purpose: state capture front end and trigger sequencer
// Assumes: pins slower than a quarter of clk
// Notes: record memory sits outside; smp feeds it
`timescale 1ns/10ps
`include "sts_defs.svh"
module sts_seq (
  input wire logic clk, // core clock
  input wire logic rst_n, // async reset
  input wire logic [`STS_NCQ-1:0] cq_pin, // clock or qualifier
  input wire logic [`STS_NCQ-1:0] cq_role, // 1 clock, 0 qualifier
  input wire logic [`STS_NCQ-1:0] cq_use, // line in use
  input wire logic [`STS_DW-1:0] din, // probed data
  input wire logic [`STS_DW-1:0][2:0] ch_off, // signed offset
  input wire logic dbl, // double-rate mode
  input wire logic pair_spare, // pod pair unassigned
  input wire logic [1:0] an_en, // analyzers enabled
  input wire logic an_timing, // analyzer as timing
  input wire logic store_dflt, // default storing
  input wire sts_pkg::sts_tpos_t trig_pos, // trigger place
  input wire logic [15:0] trig_user, // user post count
  input wire logic cfg_we, // config write
  input wire logic [7:0] cfg_addr, // config address
  input wire logic [`STS_CFG_W-1:0] cfg_data, // config data
  input wire logic start, // arm pulse
  output sts_pkg::sts_smp_t smp, // stored sample
  output logic [3:0] level, // current level
  output logic busy, // armed or filling
  output logic done, // record complete
  output logic cfg_err, // illegal setup
  output logic mem_full // full depth
);
  typedef struct packed {
    logic [`STS_NCQ-1:0] cq1, cq2, cq3;
    logic [`STS_DW-1:0] d1, d2;
    logic [`STS_HIST-1:0][`STS_DW-1:0] hist;
    logic [1:0] age;
    logic pend;
    sts_pkg::sts_pat_t [`STS_NPAT_S-1:0] pat;
    sts_pkg::sts_rng_t [`STS_NRNG_S-1:0] rng;
    sts_pkg::sts_br_t [`STS_NLVL*`STS_NBR-1:0] br;
    sts_pkg::sts_lvl_t [`STS_NLVL-1:0] lvl;
    logic [`STS_CNT_W-1:0] tlim, tmr;
    logic trun;
    logic [1:0][`STS_CNT_W-1:0] glim, gc;
    logic [`STS_NLVL-1:0][`STS_CNT_W-1:0] occ;
    logic [3:0] flg, cur;
    logic dflt, cerr, mfull;
    logic [`STS_TAG_W-1:0] tag;
    logic [15:0] post;
    sts_pkg::sts_fsm_t fsm;
    sts_pkg::sts_smp_t o;
  } sts_st_t;

  sts_st_t r, n;
  logic [`STS_HIST:0][`STS_DW-1:0] w;
  logic [`STS_DW-1:0] cap, sv;
  logic [`STS_NCQ-1:0] rise, clks, quals;
  logic edge_v, qok, smp_v, occ_hit, hit, st, trg;
  logic [`STS_NPAT_S-1:0] ph;
  logic [`STS_NRNG_S-1:0] rh;
  logic [`STS_NBR-1:0] bh;
  logic [`STS_RES_W-1:0] res;

  //////////////////////////////////////////////////////////////////
  // capture: pins pass cq1/d1 then cq2/d2 before any use
  assign w = {r.hist, r.d2};
  assign rise = r.cq2 & ~r.cq3;
  // double rate has a single clock and no qualifiers
  assign clks = dbl ? 4'h1 : cq_role & cq_use;
  assign quals = dbl ? 4'h0 : ~cq_role & cq_use;
  assign qok = &(r.cq2 | ~quals);
  assign edge_v = |(rise & clks) && qok;

  // window centre sits OFF_MAX cycles behind the newest sample, level with the edge
  for (genvar c = 0; c < `STS_DW; c++) begin : g_ch
    assign cap[c] = w[3'(`STS_OFF_MAX - ch_off[c])][c];
  end

  // timing analyzer takes every core cycle
  assign smp_v = an_timing || (r.pend && r.age == 2'h3);
  assign sv = an_timing ? r.d2 : cap;

  //////////////////////////////////////////////////////////////////
  // trigger resources
  for (genvar i = 0; i < `STS_NPAT_S; i++) begin : g_pat
    sts_pkg::sts_pat_t p;
    assign p = r.pat[i];
    assign ph[i] = (!dbl || i < `STS_NPAT_D) &&
      (p.op == sts_pkg::OP_EQ ? sv == p.val :
       p.op == sts_pkg::OP_NE ? sv != p.val :
       p.op == sts_pkg::OP_GT ? sv > p.val :
       p.op == sts_pkg::OP_GE ? sv >= p.val :
       p.op == sts_pkg::OP_LT ? sv < p.val :
       p.op == sts_pkg::OP_LE && sv <= p.val);
  end

  for (genvar i = 0; i < `STS_NRNG_S; i++) begin : g_rng
    assign rh[i] = (!dbl || i < `STS_NRNG_D) &&
      sv >= r.rng[i].lo && sv <= r.rng[i].hi;
  end

  assign occ_hit = r.occ[r.cur] >= r.lvl[r.cur].tgt;
  assign res = {r.flg, occ_hit,
    r.gc[1] == r.glim[1], r.gc[0] == r.glim[0],
    !dbl && r.tmr >= r.tlim, rh, ph};

  // each branch is an and of chosen terms, inv makes it an or
  for (genvar b = 0; b < `STS_NBR; b++) begin : g_br
    sts_pkg::sts_br_t e;
    assign e = r.br[{r.cur, 2'(b)}];
    assign bh[b] = (!dbl || b < `STS_NBR_D) &&
      (e.inv ^ &((res ~^ e.want) | ~e.mask));
  end
  assign hit = |bh;

  //////////////////////////////////////////////////////////////////
  always_comb begin
    logic [1:0] sel;
    logic [15:0] dep;
    sts_pkg::sts_br_t e;
    sts_pkg::sts_act_t act;
    sel = 2'h0;
    dep = 16'h0;
    e = '0;
    act = sts_pkg::A_GOTO;
    st = 1'b0;
    trg = 1'b0;
    n = r;
    n.cq1 = cq_pin;
    n.cq2 = r.cq1;
    n.cq3 = r.cq2;
    n.d1 = din;
    n.d2 = r.d1;
    n.hist = {r.hist[`STS_HIST-2:0], r.d2};
    n.cerr = dbl && (!pair_spare || an_en[1]);
    n.mfull = !dbl && pair_spare;
    n.o.vld = 1'b0;
    n.o.trig = 1'b0;
    if (edge_v) begin
      n.pend = 1'b1;
      n.age = 2'h1;
    end else if (r.pend) begin
      n.age = r.age + 2'h1;
      if (r.age == 2'h3) begin
        n.pend = 1'b0;
      end
    end
    if (cfg_we) begin
      if (cfg_addr[7:4] == `STS_A_PAT) begin
        n.pat[cfg_addr[3:0]] = cfg_data[$bits(sts_pkg::sts_pat_t)-1:0];
      end
      if (cfg_addr[7:4] == `STS_A_RNG && cfg_addr[3:0] < 4'he) begin
        n.rng[cfg_addr[3:0]] = cfg_data[$bits(sts_pkg::sts_rng_t)-1:0];
      end
      if (cfg_addr == `STS_A_TMR) begin
        n.tlim = cfg_data[`STS_CNT_W-1:0];
      end
      if (cfg_addr == `STS_A_GC0) begin
        n.glim[0] = cfg_data[`STS_CNT_W-1:0];
      end
      if (cfg_addr == `STS_A_GC1) begin
        n.glim[1] = cfg_data[`STS_CNT_W-1:0];
      end
      if (cfg_addr[7:6] == `STS_A_BR) begin
        n.br[cfg_addr[5:0]] = cfg_data;
      end
      if (cfg_addr[7:4] == `STS_A_LVL) begin
        n.lvl[cfg_addr[3:0]] = cfg_data[$bits(sts_pkg::sts_lvl_t)-1:0];
      end
    end
    // saturates rather than wrap, so a huge gap stays visible
    if (!(&r.tag)) begin
      n.tag = r.tag + 1'b1;
    end
    if (r.trun) begin
      n.tmr = r.tmr + 1'b1;
    end
    if (dbl) begin
      n.tmr = '0;
      n.trun = 1'b0;
    end
    case (r.fsm)
      sts_pkg::ST_IDLE, sts_pkg::ST_DONE: begin
        if (start && !r.cerr) begin
          n.fsm = sts_pkg::ST_ARM;
          n.cur = 4'h0;
          n.occ = '0;
          n.gc = '0;
          n.flg = 4'h0;
          n.tmr = '0;
          n.trun = 1'b0;
          n.dflt = store_dflt;
          n.post = 16'h0;
        end
      end
      sts_pkg::ST_ARM, sts_pkg::ST_POST: begin
        if (smp_v) begin
          st = (!dbl && r.lvl[r.cur].ovr) ? r.lvl[r.cur].st : r.dflt;
          for (int b = `STS_NBR - 1; b >= 0; b--) begin
            if (bh[b]) begin
              sel = 2'(b);
            end
          end
          if (hit) begin
            e = r.br[{r.cur, sel}];
            act = e.act;
            if (dbl && act != sts_pkg::A_TRIG) begin
              act = sts_pkg::A_GOTO;
            end
            if (!(&r.occ[r.cur])) begin
              n.occ[r.cur] = r.occ[r.cur] + 1'b1;
            end
            if (act != sts_pkg::A_TRIG) begin
              n.cur = e.next;
            end
            case (act)
              sts_pkg::A_TRIG, sts_pkg::A_TRGO: trg = 1'b1;
              sts_pkg::A_STORE: st = 1'b1;
              sts_pkg::A_SKIP: st = 1'b0;
              sts_pkg::A_DON: n.dflt = 1'b1;
              sts_pkg::A_DOFF: n.dflt = 1'b0;
              sts_pkg::A_TSTA: begin
                n.tmr = '0;
                n.trun = 1'b1;
              end
              sts_pkg::A_TSTP: begin
                n.tmr = '0;
                n.trun = 1'b0;
              end
              sts_pkg::A_TPAU: n.trun = 1'b0;
              sts_pkg::A_TRES: n.trun = 1'b1;
              sts_pkg::A_GINC: n.gc[e.arg[0]] = r.gc[e.arg[0]] + 1'b1;
              sts_pkg::A_GDEC: n.gc[e.arg[0]] = r.gc[e.arg[0]] - 1'b1;
              sts_pkg::A_GRST: n.gc[e.arg[0]] = '0;
              sts_pkg::A_ORST: n.occ[r.cur] = '0;
              sts_pkg::A_FSET: n.flg[e.arg] = 1'b1;
              sts_pkg::A_FCLR: n.flg[e.arg] = 1'b0;
              default: ;
            endcase
          end
          dep = r.mfull ? `STS_DEPTH : `STS_DEPTH >> 1;
          if (trg && r.fsm == sts_pkg::ST_ARM) begin
            st = 1'b1;
            n.o.trig = 1'b1;
            n.fsm = sts_pkg::ST_POST;
            case (trig_pos)
              sts_pkg::TP_START: n.post = dep - 16'h1;
              sts_pkg::TP_CENTER: n.post = dep >> 1;
              sts_pkg::TP_END: n.post = 16'h0;
              default: n.post = trig_user < dep ? trig_user : dep - 16'h1;
            endcase
            if (n.post == 16'h0) begin
              n.fsm = sts_pkg::ST_DONE;
            end
          end else if (st && r.fsm == sts_pkg::ST_POST) begin
            n.post = r.post - 16'h1;
            if (r.post <= 16'h1) begin
              n.fsm = sts_pkg::ST_DONE;
            end
          end
          if (st) begin
            n.o.vld = 1'b1;
            n.o.data = sv;
            n.o.tag = r.tag;
            n.tag = {{(`STS_TAG_W-1){1'b0}}, 1'b1};
          end
        end
      end
      default: n.fsm = sts_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r <= '0;
      r.fsm <= sts_pkg::ST_IDLE;
    end else begin
      r <= n;
    end
  end

  assign smp = r.o;
  assign level = r.cur;
  assign busy = r.fsm == sts_pkg::ST_ARM || r.fsm == sts_pkg::ST_POST;
  assign done = r.fsm == sts_pkg::ST_DONE;
  assign cfg_err = r.cerr;
  assign mem_full = r.mfull;

  //////////////////////////////////////////////////////////////////
  sequence edge_s;
    edge_v && !an_timing;
  endsequence
  sequence cap_s;
    r.pend && r.age == 2'h3;
  endsequence

  cap_delay_a: assert property (@(posedge clk) disable iff (!rst_n)
    edge_s ##1 !edge_v [*2] |-> ##1 cap_s)
    else $error("capture not three cycles after edge");
  zero_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    cap_s and ch_off[0] == 3'h0 and !an_timing
    |-> sv[0] == $past(r.d2[0], 3))
    else $error("zero offset sample misplaced");
  neg_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    cap_s and ch_off[1] == 3'h7 and !an_timing
    |-> sv[1] == $past(r.d2[1], 4))
    else $error("negative offset sample misplaced");
  pos_off_a: assert property (@(posedge clk) disable iff (!rst_n)
    cap_s and ch_off[2] == 3'h2 and !an_timing
    |-> sv[2] == $past(r.d2[2], 1))
    else $error("positive offset sample misplaced");
  one_an_a: assert property (@(posedge clk) disable iff (!rst_n)
    dbl && an_en[1] && !busy |=> cfg_err ##1 !busy)
    else $error("second analyzer allowed in double rate");
  spare_pair_a: assert property (@(posedge clk) disable iff (!rst_n)
    dbl && !pair_spare |=> cfg_err)
    else $error("double rate without spare pair");
  depth_a: assert property (@(posedge clk) disable iff (!rst_n)
    1'b1 |=> mem_full == $past(!dbl && pair_spare))
    else $error("memory depth select wrong");
  two_way_a: assert property (@(posedge clk) disable iff (!rst_n)
    dbl && busy && smp_v && bh[1:0] == 2'h0
    |=> $stable(level) && !smp.trig)
    else $error("upper branch live in double rate");
  no_timer_a: assert property (@(posedge clk) disable iff (!rst_n)
    dbl [*2] |-> r.tmr == '0)
    else $error("timer runs in double rate");
  glob_store_a: assert property (@(posedge clk) disable iff (!rst_n)
    dbl && smp_v && busy && !trg |-> st == r.dflt)
    else $error("level store used in double rate");
  trig_end_a: assert property (@(posedge clk) disable iff (!rst_n)
    busy && !r.fsm[2] && smp_v && trg && trig_pos == sts_pkg::TP_END
    |=> done && smp.trig && smp.vld)
    else $error("end trigger did not close record");
  tag_step_a: assert property (@(posedge clk) disable iff (!rst_n)
    smp.vld ##1 smp.vld |-> smp.tag == 1'b1)
    else $error("back to back tag not one");
endmodule

/* dv/sts_sut.sv */
// Purpose: system under test model, state clock on line 0 plus data
// Assumes: 50 ns slots, 12 ns ahead of each core clock rise
// Notes: clock period 400 ns, clock pin idles low between frames
`timescale 1ns/10ps
module sts_sut (
  input wire logic run, // frame on
  output logic [3:0] pin, // clock and qualifier lines
  output logic [15:0] din, // probed data
  output logic [15:0] rise // slot of the last clock rise
);
  logic [15:0] slot;
  function automatic logic [15:0] pat(input logic [15:0] s);
    return s * 16'h9e37 ^ 16'h5ac3;
  endfunction
  initial begin
    slot = 16'h0000;
    pin = 4'h0;
    rise = 16'h0000;
    din = pat(slot);
    #13;
    forever begin
      #50;
      slot = slot + 16'h0001;
      // data moves every slot so a stale or early sample shows
      din = pat(slot);
      if (run && slot[2:0] == 3'h0) begin
        pin[0] = 1'b1;
        rise = slot;
      end else if (slot[2:0] == 3'h4) begin
        pin[0] = 1'b0;
      end
    end
  end
endmodule

/* dv/test_sts_seq.sv */
// Purpose: self-checking bench of the state trigger sequencer
// Assumes: data slot of channel c is clock rise slot plus its offset
// Notes: outputs are sampled on the falling clock edge
`timescale 1ns/10ps
module test_sts_seq;
  logic clk, rst_n, run, dbl, pair_spare, store_dflt, cfg_we, start;
  logic [3:0] cq_pin, cq_use;
  logic an_timing;
  logic [15:0] din, rise, trig_user;
  logic [15:0][2:0] ch_off;
  logic [1:0] an_en;
  sts_pkg::sts_tpos_t trig_pos;
  logic [7:0] cfg_addr;
  logic [87:0] cfg_data;
  sts_pkg::sts_smp_t smp;
  logic [3:0] level;
  logic busy, done, cfg_err, mem_full;
  int mismatches, check_count;
  logic [31:0] rng;
  sts_sut u_sts_sut (.run(run), .pin(cq_pin), .din(din), .rise(rise));
  sts_seq u_sts_seq (.clk(clk), .rst_n(rst_n), .cq_pin(cq_pin),
    .cq_role(4'h1), .cq_use(cq_use), .din(din), .ch_off(ch_off), .dbl(dbl),
    .pair_spare(pair_spare), .an_en(an_en), .an_timing(an_timing),
    .store_dflt(store_dflt), .trig_pos(trig_pos), .trig_user(trig_user),
    .cfg_we(cfg_we), .cfg_addr(cfg_addr), .cfg_data(cfg_data),
    .start(start), .smp(smp), .level(level), .busy(busy), .done(done),
    .cfg_err(cfg_err), .mem_full(mem_full));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] xs();
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return rng;
  endfunction
  function automatic logic [15:0] pat(input logic [15:0] s);
    return s * 16'h9e37 ^ 16'h5ac3;
  endfunction
  function automatic logic [15:0] dexp();
    logic [15:0] r;
    logic [15:0] v;
    for (int c = 0; c < 16; c++) begin
      v = pat(rise + {{13{ch_off[c][2]}}, ch_off[c]});
      r[c] = v[c];
    end
    return r;
  endfunction
  function automatic logic hit(input int k, input logic [15:0] d);
    case (k)
      0: return d == 16'h8000;
      1: return d != 16'h8000;
      2: return d > 16'h8000;
      3: return d >= 16'h8000;
      4: return d < 16'h8000;
      5: return d <= 16'h8000;
      6: return d >= 16'h4000 && d <= 16'hc000;
      default: return d < 16'h4000 || d > 16'hc000;
    endcase
  endfunction
  ////////////////////////////////////////////////////////////////////////
  task automatic chk_word(input logic [47:0] got, input logic [47:0] exp);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_flag(input logic got, input logic exp);
    chk_word({47'h0, got}, {47'h0, exp});
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk);
    run <= 1'b0;
    rst_n <= 1'b0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [87:0] d);
    @(posedge clk);
    cfg_we <= 1'b1;
    cfg_addr <= a;
    cfg_data <= d;
    @(posedge clk);
    cfg_we <= 1'b0;
  endtask
  task automatic pulse_start();
    @(posedge clk);
    start <= 1'b1;
    @(posedge clk);
    start <= 1'b0;
  endtask
  task automatic arm();
    pulse_start();
    run <= 1'b1;
  endtask
  // the next sample stored within 40 cycles is checked for its per-channel capture slot
  task automatic get();
    logic got;
    got = 1'b0;
    for (int i = 0; i < 40 && !got; i++) begin
      @(negedge clk);
      got = (smp.vld === 1'b1);
    end
    chk_flag(got, 1'b1);
    if (got) chk_word({32'h0, smp.data}, {32'h0, dexp()});
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  initial begin
    #2000000;
    mismatches++;
    print_verdict();
  end
  initial begin
    logic [37:0] b;
    logic [31:0] w;
    int n;
    logic [1:0][15:0] dh;
    rng = 32'd82766;
    {rst_n, run, dbl, cfg_we, start, cfg_addr, cfg_data} = '0;
    {pair_spare, store_dflt, an_en} = 4'hf;
    an_en = 2'h1;
    trig_pos = sts_pkg::TP_END;
    trig_user = 16'h0000;
    ch_off = '0;
    an_timing = 1'b0;
    cq_use = 4'h1;
    do_reset();
    @(negedge clk);
    chk_word({42'h0, busy, done, level}, 48'h0);
    for (int i = 0; i < 8; i++) begin
      @(posedge clk);
      dbl <= i[0];
      pair_spare <= i[1];
      an_en <= {i[2], 1'b1};
      repeat (3) @(negedge clk);
      chk_flag(cfg_err, i[0] && (!i[1] || i[2]));
      chk_flag(mem_full, !i[0] && i[1]);
      if (cfg_err === 1'b1) begin
        pulse_start();
        repeat (2) @(negedge clk);
        chk_flag(busy, 1'b0);
      end
    end
    $display("test setup checks done");
    do_reset();
    {dbl, pair_spare, an_en} <= 4'h3;
    for (int r = 0; r < 5; r++) begin
      @(posedge clk);
      run <= 1'b0;
      repeat (16) @(posedge clk);
      for (int c = 0; c < 16; c++) begin
        w = xs();
        // round 3: -1 on channel 1, +2 on channel 2, zero on channel 0
        ch_off[c] <= r == 0 ? 3'h0 : r == 1 ? 3'h4 : r == 2 ? 3'h3 :
          r == 4 ? w[2:0] : c == 1 ? 3'h7 : 3'(c);
      end
      if (r == 0) pulse_start();
      run <= 1'b1;
      for (int k = 0; k < 6; k++) begin
        get();
        if (k > 0) chk_word({2'h0, smp.tag}, 48'h8);
      end
    end
    $display("test sample offsets done");
    for (int k = 0; k < 8; k++) begin
      do_reset();
      if (k < 6) wr(8'h00, {69'h0, k[2:0], 16'h8000});
      else wr(8'h10, {56'h0, 16'hc000, 16'h4000});
      b = k < 6 ? 38'h1 : 38'h10000;
      wr(8'h40, {b, b, k == 7, 4'h0, 5'h01, 2'h0});
      arm();
      for (n = 0; n < 12 && done !== 1'b1; n++) begin
        get();
        chk_flag(smp.trig, hit(k, smp.data));
        chk_flag(done, hit(k, smp.data));
      end
    end
    $display("test comparators done");
    for (int t = 0; t < 5; t++) begin
      do_reset();
      w = xs();
      pair_spare <= t != 4;
      trig_pos <= sts_pkg::sts_tpos_t'(t == 4 ? 3 : t);
      trig_user <= t == 4 ? 16'hffff : {10'h0, w[5:0]};
      n = t == 0 ? 1023 : t == 1 ? 512 : t == 2 ? 0 : t == 3 ? w[5:0] : 511;
      wr(8'h40, {81'h0, 5'h01, 2'h0});
      arm();
      get();
      chk_flag(smp.trig, 1'b1);
      chk_flag(done, n == 0);
      for (int i = 0; i < n; i++) begin
        get();
        chk_word({2'h0, smp.tag}, 48'h8);
        chk_flag(done, i == n - 1);
      end
    end
    $display("test trigger positions done");
    for (int m = 0; m < 2; m++) begin
      do_reset();
      dbl <= m[0];
      pair_spare <= 1'b1;
      an_en <= 2'h1;
      trig_pos <= sts_pkg::TP_END;
      // first two branches never hit, so only a third branch can trigger
      wr(8'h40, {76'h0, 1'b1, 11'h0});
      wr(8'h41, {76'h0, 1'b1, 11'h0});
      wr(8'h42, {81'h0, 5'h01, 2'h0});
      wr(8'h80, {5'h0, 1'b1, 1'b0, 81'h0});
      arm();
      get();
      chk_flag(smp.trig, m == 0);
    end
    $display("test double rate done");
    // a qualifier line held low must block every clock edge
    do_reset();
    dbl <= 1'b0;
    cq_use <= 4'h3;
    arm();
    for (int i = 0; i < 40; i++) begin
      @(negedge clk);
      chk_flag(smp.vld, 1'b0);
    end
    @(posedge clk);
    cq_use <= 4'h1;
    get();
    $display("test qualifier done");
    // timing analyzer stores every cycle, two sync stages behind the pins
    do_reset();
    an_timing <= 1'b1;
    arm();
    for (int i = 0; i < 10; i++) begin
      @(negedge clk);
      if (i > 1) begin
        chk_word({32'h0, smp.data}, {32'h0, dh[1]});
        chk_word({2'h0, smp.tag}, 48'h1);
      end
      dh = {dh[0], din};
    end
    $display("test timing analyzer done");
    print_verdict();
  end
endmodule

/* shared/sts_defs.svh */
// Purpose: constants of the state trigger sequencer
// Assumes: one 20 MHz core clock samples every pin
// Notes: sized for a 16 channel build
// Operation
// - negative offset samples before the clock edge
// - positive offset samples after the clock edge
// - zero offset samples at the clock edge
// - every data channel has its own offset
// - standard mode: full depth needs spare pair
// - double rate needs a spare pod pair
// - double rate allows only one analyzer
// - analyzer runs as state or timing
// - four clock and qualifier lines at most
// - time tag per store, spans 32 days
// - sixteen sequence levels in both modes
// - sequencer steps once per captured sample
// - four branches standard, two double rate
// - trigger at start, centre, end or user
// - pattern comparators: sixteen or fourteen
// - range comparators: fourteen or seven
// - one timer per 34 channels, standard only
// - one occurrence counter per level
// - full action set in standard mode
// - double rate: go to and trigger only
// - per level store qualifier, standard only
`ifndef STS_DEFS_SVH
`define STS_DEFS_SVH
`define STS_DW 16
`define STS_NCQ 4
`define STS_OFF_MAX 3'h3
`define STS_HIST 7
`define STS_NPAT_S 16
`define STS_NPAT_D 14
`define STS_NRNG_S 14
`define STS_NRNG_D 7
`define STS_NLVL 16
`define STS_NBR 4
`define STS_NBR_D 2
`define STS_RES_W 38
`define STS_CNT_W 81
`define STS_CFG_W 88
`define STS_CLK_NS 50
`define STS_TAG_DAYS 64'h20
`define STS_DAY_NS 64'h4e94914f0000
`define STS_TAG_W $clog2(`STS_TAG_DAYS * `STS_DAY_NS / `STS_CLK_NS)
`define STS_DEPTH 16'h0400
`define STS_A_PAT 4'h0
`define STS_A_RNG 4'h1
`define STS_A_TMR 8'h20
`define STS_A_GC0 8'h22
`define STS_A_GC1 8'h23
`define STS_A_BR 2'h1
`define STS_A_LVL 4'h8
`endif

/* shared/sts_pkg.sv */
// Purpose: types of the state trigger sequencer
// Assumes: sts_defs.svh sets the widths
// Notes: structs carry config entries and samples
`include "sts_defs.svh"
package sts_pkg;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h1,
    ST_ARM = 4'h2,
    ST_POST = 4'h4,
    ST_DONE = 4'h8
  } sts_fsm_t;
  typedef enum logic [4:0] {
    A_GOTO, A_TRIG, A_TRGO, A_STORE, A_SKIP, A_DON, A_DOFF,
    A_TSTA, A_TSTP, A_TPAU, A_TRES, A_GINC, A_GDEC, A_GRST,
    A_ORST, A_FSET, A_FCLR
  } sts_act_t;
  typedef enum logic [2:0] {
    OP_EQ, OP_NE, OP_GT, OP_GE, OP_LT, OP_LE
  } sts_op_t;
  typedef enum logic [1:0] {
    TP_START, TP_CENTER, TP_END, TP_USER
  } sts_tpos_t;
  typedef struct packed {
    logic [`STS_RES_W-1:0] mask;
    logic [`STS_RES_W-1:0] want;
    logic inv;
    logic [3:0] next;
    sts_act_t act;
    logic [1:0] arg;
  } sts_br_t;
  typedef struct packed {
    sts_op_t op;
    logic [`STS_DW-1:0] val;
  } sts_pat_t;
  typedef struct packed {
    logic [`STS_DW-1:0] hi;
    logic [`STS_DW-1:0] lo;
  } sts_rng_t;
  typedef struct packed {
    logic ovr;
    logic st;
    logic [`STS_CNT_W-1:0] tgt;
  } sts_lvl_t;
  typedef struct packed {
    logic vld;
    logic trig;
    logic [`STS_DW-1:0] data;
    logic [`STS_TAG_W-1:0] tag;
  } sts_smp_t;
endpackage
